// File: logic/stcb_consts.vh
// constants shared by the scan timer and counter bank
`ifndef STCB_CONSTS_VH
`define STCB_CONSTS_VH

// clock and time bases
`define STCB_CLK_PERIOD_NS  40
`define STCB_UNIT_1MS_NS    1000000
`define STCB_UNIT_100MS_MS  100
`define STCB_TICK_1MS_CYC   (`STCB_UNIT_1MS_NS / `STCB_CLK_PERIOD_NS)

// bank geometry
`define STCB_ENTRIES        512
`define STCB_IDX_W          9
`define STCB_VAL_W          16
`define STCB_RSV_FIRST      412
`define STCB_RSV_LAST       511
`define STCB_CNT_LATCH_BASE 256

// counter limits
`define STCB_CNT_MAX        16'h7fff
`define STCB_CNT_ONE        16'h0001
`define STCB_SET_MASK       16'h7fff

// operation codes
`define STCB_OP_W           3
`define STCB_OP_TMR100      3'h0
`define STCB_OP_TMR1MS      3'h1
`define STCB_OP_COUNT       3'h2
`define STCB_OP_CLR_TMR     3'h3
`define STCB_OP_CLR_CNT     3'h4
`define STCB_OP_MOVE        3'h5
`define STCB_OP_END_SCAN    3'h6

// reset values
`define STCB_VAL_RST        16'h0000

`endif

// File: logic/stcb_tick_gen.v
// divider that turns the system clock into 1 ms and 100 ms tick pulses
`timescale 1ns/100ps
`default_nettype none
`include "stcb_consts.vh"

module stcb_tick_gen #(
    parameter integer TICK_1MS_CYCLES = `STCB_TICK_1MS_CYC
) (
    input  wire        sys_clk,
    input  wire        rst,
    output reg         tick_1ms,
    output reg         tick_100ms
);

    reg [31:0] clk_cnt;
    reg [7:0]  ms_cnt;

    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            clk_cnt    <= 32'h0000_0000;
            ms_cnt     <= 8'h00;
            tick_1ms   <= 1'b0;
            tick_100ms <= 1'b0;
        end
        else
        begin
            tick_1ms   <= 1'b0;
            tick_100ms <= 1'b0;
            if (clk_cnt == TICK_1MS_CYCLES - 1)
            begin
                clk_cnt  <= 32'h0000_0000;
                tick_1ms <= 1'b1;
                if (ms_cnt == `STCB_UNIT_100MS_MS - 1)
                begin
                    ms_cnt     <= 8'h00;
                    tick_100ms <= 1'b1;
                end
                else
                begin
                    ms_cnt <= ms_cnt + 8'h01;
                end
            end
            else
            begin
                clk_cnt <= clk_cnt + 32'h0000_0001;
            end
        end
    end

endmodule // stcb_tick_gen
`default_nettype wire

// File: logic/stcb_bank.v
// bank of 512 scan timers and 512 16-bit up counters driven by controller operations
`timescale 1ns/100ps
`default_nettype none
`include "stcb_consts.vh"

module stcb_bank #(
    parameter integer TICK_1MS_CYCLES = `STCB_TICK_1MS_CYC
) (
    input  wire                     sys_clk,
    input  wire                     rst,
    input  wire                     power_fail,
    input  wire                     op_valid,
    input  wire [`STCB_OP_W-1:0]    op_code,
    input  wire [`STCB_IDX_W-1:0]   op_index,
    input  wire                     enable_input,
    input  wire                     op_accum,
    input  wire                     count_input,
    input  wire [`STCB_VAL_W-1:0]   op_setting,
    input  wire                     rd_req,
    input  wire                     rd_sel,
    input  wire [`STCB_IDX_W-1:0]   rd_index,
    output wire [`STCB_ENTRIES-1:0] timer_out,
    output wire [`STCB_ENTRIES-1:0] counter_out,
    output reg                      rd_valid,
    output reg  [`STCB_VAL_W-1:0]   rd_value
);

    wire                   tick_1ms;
    wire                   tick_100ms;
    reg  [`STCB_VAL_W-1:0] now_1ms;
    reg  [`STCB_VAL_W-1:0] now_100ms;
    reg                    pf_meta;
    reg                    pf_sync;
    reg                    pf_prev;
    wire                   pwr_loss;
    wire [`STCB_VAL_W-1:0] tmr_val [0:`STCB_ENTRIES-1];
    wire [`STCB_VAL_W-1:0] cnt_val [0:`STCB_ENTRIES-1];

    wire op_tmr    = op_valid & ((op_code == `STCB_OP_TMR100) | (op_code == `STCB_OP_TMR1MS));
    wire op_unit   = (op_code == `STCB_OP_TMR1MS);
    wire op_cnt    = op_valid & (op_code == `STCB_OP_COUNT);
    wire op_clr_t  = op_valid & (op_code == `STCB_OP_CLR_TMR);
    wire op_clr_c  = op_valid & (op_code == `STCB_OP_CLR_CNT);
    wire op_move   = op_valid & (op_code == `STCB_OP_MOVE);
    wire op_end    = op_valid & (op_code == `STCB_OP_END_SCAN);

    // setting range is 0-32767, and 0 behaves as 1
    wire [`STCB_VAL_W-1:0] cnt_set = op_setting & `STCB_SET_MASK;
    wire [`STCB_VAL_W-1:0] cnt_eff = (cnt_set == `STCB_VAL_RST) ? `STCB_CNT_ONE : cnt_set;

    function [`STCB_VAL_W-1:0] stcb_inc;
        input [`STCB_VAL_W-1:0] v;
        begin
            stcb_inc = (v >= `STCB_CNT_MAX) ? `STCB_VAL_RST : v + `STCB_CNT_ONE;
        end
    endfunction

    stcb_tick_gen #(
        .TICK_1MS_CYCLES (TICK_1MS_CYCLES)
    ) u_tick (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .tick_1ms   (tick_1ms),
        .tick_100ms (tick_100ms)
    );

    // free-running time bases; each timer keeps a stamp so elapsed units are
    // credited when its operation runs, however long the scan took
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            now_1ms   <= `STCB_VAL_RST;
            now_100ms <= `STCB_VAL_RST;
        end
        else
        begin
            if (tick_1ms)
                now_1ms <= now_1ms + `STCB_CNT_ONE;
            if (tick_100ms)
                now_100ms <= now_100ms + `STCB_CNT_ONE;
        end
    end

    // power supervisor is asynchronous to sys_clk
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            pf_meta <= 1'b0;
            pf_sync <= 1'b0;
            pf_prev <= 1'b0;
        end
        else
        begin
            pf_meta <= power_fail;
            pf_sync <= pf_meta;
            pf_prev <= pf_sync;
        end
    end

    assign pwr_loss = pf_sync & ~pf_prev;

    genvar i;
    generate
        for (i = 0; i < `STCB_ENTRIES; i = i + 1)
        begin : g_entry
            localparam [0:0] RSV   = (i >= `STCB_RSV_FIRST && i <= `STCB_RSV_LAST) ? 1'b1 : 1'b0;
            localparam [0:0] LATCH = (i >= `STCB_CNT_LATCH_BASE) ? 1'b1 : 1'b0;

            reg  [`STCB_VAL_W-1:0] t_val;
            reg  [`STCB_VAL_W-1:0] t_stamp;
            reg  [`STCB_VAL_W-1:0] t_set;
            reg                    t_unit;
            reg                    t_taken;
            reg                    t_en_fail;
            reg                    t_run;
            reg                    t_accum;
            reg                    t_out;
            reg  [`STCB_VAL_W-1:0] c_val;
            reg                    c_prev;
            reg                    c_pend;
            reg                    c_out;

            wire hit      = (op_index == i);
            wire [`STCB_VAL_W-1:0] u_set  = t_taken ? t_set : op_setting;
            wire                   u_unit = t_taken ? t_unit : op_unit;
            wire [`STCB_VAL_W-1:0] now_u  = u_unit ? now_1ms : now_100ms;
            wire [`STCB_VAL_W-1:0] now_s  = t_unit ? now_1ms : now_100ms;
            wire [`STCB_VAL_W-1:0] adv    = t_run ? t_val + (now_u - t_stamp) : t_val;
            wire [`STCB_VAL_W-1:0] adv_s  = t_val + (now_s - t_stamp);
            wire                   reach  = (adv >= u_set);

            always @(posedge sys_clk)
            begin
                if (rst)
                begin
                    t_val     <= `STCB_VAL_RST;
                    t_stamp   <= `STCB_VAL_RST;
                    t_set     <= `STCB_VAL_RST;
                    t_unit    <= 1'b0;
                    t_taken   <= 1'b0;
                    t_en_fail <= 1'b0;
                    t_run     <= 1'b0;
                    t_accum   <= 1'b0;
                    t_out     <= 1'b0;
                end
                else if (pwr_loss)
                begin
                    t_run <= 1'b0;
                    t_out <= 1'b0;
                    if (!t_accum)
                        t_val <= `STCB_VAL_RST;
                    // accumulative value is kept here
                end
                else if (op_tmr && hit)
                begin
                    t_taken <= 1'b1;
                    t_set   <= u_set;
                    t_unit  <= u_unit;
                    t_accum <= op_accum;
                    if (enable_input)
                    begin
                        t_run   <= 1'b1;
                        t_stamp <= now_u;
                        if (t_out && !reach && !t_en_fail)
                        begin
                            t_val <= `STCB_VAL_RST;
                            t_out <= 1'b0;
                        end
                        else
                        begin
                            t_val <= adv;
                            t_out <= reach & ~t_en_fail;
                        end
                    end
                    else
                    begin
                        t_run     <= 1'b0;
                        t_en_fail <= 1'b1;
                        t_out     <= 1'b0;
                        if (!op_accum)
                            t_val <= `STCB_VAL_RST;
                    end
                end
                else if (op_clr_t && hit)
                begin
                    t_val <= `STCB_VAL_RST;
                    t_run <= 1'b0;
                    t_out <= 1'b0;
                end
                else if (op_end)
                begin
                    t_taken   <= 1'b0;
                    t_en_fail <= 1'b0;
                    // reserved timers may sit in code that is skipped this scan
                    if (RSV && t_run)
                    begin
                        t_val   <= adv_s;
                        t_stamp <= now_s;
                        t_out   <= (adv_s >= t_set) & ~t_en_fail;
                    end
                end
            end

            always @(posedge sys_clk)
            begin
                if (rst)
                begin
                    c_val  <= `STCB_VAL_RST;
                    c_prev <= 1'b0;
                    c_pend <= 1'b0;
                    c_out  <= 1'b0;
                end
                else if (pwr_loss)
                begin
                    if (!LATCH)
                    begin
                        c_val  <= `STCB_VAL_RST;
                        c_prev <= 1'b0;
                        c_pend <= 1'b0;
                        c_out  <= 1'b0;
                    end
                end
                else if (op_clr_c && hit)
                begin
                    c_val  <= `STCB_VAL_RST;
                    c_pend <= 1'b0;
                    c_out  <= 1'b0;
                end
                else if (op_move && hit)
                begin
                    c_val <= op_setting;
                end
                else if (op_cnt && hit)
                begin
                    c_prev <= count_input;
                    if (count_input && !c_prev)
                    begin
                        if (c_val > cnt_set && c_val >= cnt_eff)
                        begin
                            c_val  <= cnt_set;
                            c_pend <= 1'b1;
                        end
                        else if (c_val >= cnt_eff)
                        begin
                            c_pend <= 1'b1;
                        end
                        else
                        begin
                            c_val  <= stcb_inc(c_val);
                            c_pend <= (stcb_inc(c_val) >= cnt_eff);
                        end
                    end
                end
                else if (op_end)
                begin
                    c_out <= c_pend;
                end
            end

            assign timer_out[i]   = t_out;
            assign counter_out[i] = c_out;
            assign tmr_val[i]     = t_val;
            assign cnt_val[i]     = c_val;
        end
    endgenerate

    // one read port; accumulative and ordinary timers answer at the same number
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            rd_valid <= 1'b0;
            rd_value <= `STCB_VAL_RST;
        end
        else
        begin
            rd_valid <= rd_req;
            if (rd_req)
                rd_value <= rd_sel ? cnt_val[rd_index] : tmr_val[rd_index];
        end
    end

endmodule // stcb_bank
`default_nettype wire

// File: tb/stcb_bank_props.sv
// port checker for the scan timer and counter bank
`timescale 1ns/100ps
`default_nettype none
`include "stcb_consts.vh"
module stcb_bank_props (
    input wire logic                     sys_clk,
    input wire logic                     rst,
    input wire logic                     power_fail,
    input wire logic                     op_valid,
    input wire logic [`STCB_OP_W-1:0]    op_code,
    input wire logic [`STCB_IDX_W-1:0]   op_index,
    input wire logic                     enable_input,
    input wire logic                     op_accum,
    input wire logic                     count_input,
    input wire logic [`STCB_VAL_W-1:0]   op_setting,
    input wire logic                     rd_req,
    input wire logic                     rd_sel,
    input wire logic [`STCB_IDX_W-1:0]   rd_index,
    input wire logic [`STCB_ENTRIES-1:0] timer_out,
    input wire logic [`STCB_ENTRIES-1:0] counter_out,
    input wire logic                     rd_valid,
    input wire logic [`STCB_VAL_W-1:0]   rd_value
);
    // power edge beats an op through the sync stages, so skip those cycles
    logic [5:0] pf_hist;
    logic       quiet;
    always @(posedge sys_clk)
        pf_hist <= rst ? 6'h00 : {pf_hist[4:0], power_fail};
    assign quiet = (pf_hist == 6'h00) && !power_fail;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    rd_answer_a: assert property (rd_req |=> rd_valid) else $error("read not answered");
    rd_single_a: assert property (!rd_req |=> !rd_valid) else $error("read valid without request");
    rd_hold_a: assert property (!rd_req |=> $stable(rd_value)) else $error("read value moved");
    cnt_publish_a: assert property ((counter_out & ~$past(counter_out)) != 0 |->
        $past(op_valid && op_code == `STCB_OP_END_SCAN)) else $error("counter out rose outside scan end");
    cnt_clear_a: assert property (op_valid && op_code == `STCB_OP_CLR_CNT && quiet |=>
        !counter_out[$past(op_index)]) else $error("counter out kept after clear");
    tmr_off_a: assert property (op_valid && !op_code[2:1] && !enable_input && quiet |=>
        !timer_out[$past(op_index)]) else $error("timer out on while disabled");
    tmr_rise_a: assert property ((timer_out & ~$past(timer_out)) != 0 |-> $past(op_valid) &&
        ($past(op_code) <= `STCB_OP_TMR1MS || $past(op_code) == `STCB_OP_END_SCAN))
        else $error("timer out rose without timer op");
    latch_keep_a: assert property ((~counter_out[511:256] & $past(counter_out[511:256])) != 0 |->
        $past(op_valid && op_code == `STCB_OP_CLR_CNT)) else $error("latched counter out lost");
endmodule // stcb_bank_props
`default_nettype wire

// File: tb/stcb_bank_tb_top.sv
// self-checking bench for the scan timer and counter bank
`timescale 1ns/100ps
`default_nettype none
`include "stcb_consts.vh"
module stcb_bank_tb_top;
    logic sys_clk = 1'b0, rst = 1'b1, power_fail = 1'b0, op_valid = 1'b0, enable_input = 1'b0, op_accum = 1'b0;
    logic count_input = 1'b0, rd_req = 1'b0, rd_sel = 1'b0, rd_valid;
    logic [2:0] op_code = 3'h0;
    logic [8:0] op_index = 9'h000, rd_index = 9'h000;
    logic [15:0] op_setting = 16'h0000, rd_value;
    logic [511:0] timer_out, counter_out;
    int bad_count = 0, n_compared = 0;
    always #20 sys_clk = ~sys_clk;
    stcb_bank #(.TICK_1MS_CYCLES(10)) stcb_bank_inst (.sys_clk(sys_clk), .rst(rst), .power_fail(power_fail),
        .op_valid(op_valid), .op_code(op_code), .op_index(op_index), .enable_input(enable_input),
        .op_accum(op_accum), .count_input(count_input), .op_setting(op_setting), .rd_req(rd_req),
        .rd_sel(rd_sel), .rd_index(rd_index), .timer_out(timer_out), .counter_out(counter_out),
        .rd_valid(rd_valid), .rd_value(rd_value));
    task automatic cmp_val(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // one op occupies two edges so op_valid is never driven twice in a step
    task automatic op(input logic [2:0] c, input logic [8:0] i, input logic en, acc, cnt, input logic [15:0] s);
        @(posedge sys_clk);
        {op_valid, op_code, op_index} <= {1'b1, c, i};
        {enable_input, op_accum, count_input, op_setting} <= {en, acc, cnt, s};
        @(posedge sys_clk);
        op_valid <= 1'b0;
    endtask
    task automatic chk_rd(input string nm, input logic sel, input logic [8:0] i, input logic [15:0] e);
        @(posedge sys_clk);
        {rd_req, rd_sel, rd_index} <= {1'b1, sel, i};
        @(posedge sys_clk);
        rd_req <= 1'b0;
        #1;
        cmp_bit("rd_valid", 1'b1, rd_valid);
        cmp_val(nm, e, rd_value);
    endtask
    task automatic edge_cnt(input logic [8:0] i, input logic [15:0] s);
        op(`STCB_OP_COUNT, i, 1'b0, 1'b0, 1'b0, s);
        op(`STCB_OP_COUNT, i, 1'b0, 1'b0, 1'b1, s);
    endtask
    task automatic t_timers;
        cmp_bit("outputs after reset", 1'b0, |{timer_out, counter_out});
        op(`STCB_OP_TMR100, 9'd5, 1'b1, 1'b0, 1'b0, 16'h0003);
        idle(1998);
        op(`STCB_OP_TMR100, 9'd5, 1'b1, 1'b0, 1'b0, 16'h0003);
        chk_rd("timer5 two units", 1'b0, 9'd5, 16'h0002);
        cmp_bit("timer5 below setting", 1'b0, timer_out[5]);
        idle(996);
        op(`STCB_OP_TMR100, 9'd5, 1'b1, 1'b0, 1'b0, 16'h0003);
        chk_rd("timer5 three units", 1'b0, 9'd5, 16'h0003);
        cmp_bit("timer5 at setting", 1'b1, timer_out[5]);
        op(`STCB_OP_TMR100, 9'd5, 1'b0, 1'b0, 1'b0, 16'h0003);
        chk_rd("timer5 disabled", 1'b0, 9'd5, 16'h0000);
        cmp_bit("timer5 out disabled", 1'b0, timer_out[5]);
        op(`STCB_OP_TMR1MS, 9'd6, 1'b1, 1'b0, 1'b0, 16'h0014);
        idle(48);
        op(`STCB_OP_TMR1MS, 9'd6, 1'b1, 1'b0, 1'b0, 16'h0014);
        chk_rd("timer6 five ms", 1'b0, 9'd6, 16'h0005);
        op(`STCB_OP_TMR1MS, 9'd7, 1'b1, 1'b0, 1'b0, 16'h0002);
        idle(28);
        op(`STCB_OP_TMR100, 9'd7, 1'b1, 1'b0, 1'b0, 16'h0064);
        chk_rd("timer7 first setting", 1'b0, 9'd7, 16'h0003);
        cmp_bit("timer7 out first setting", 1'b1, timer_out[7]);
        op(`STCB_OP_END_SCAN, 9'd0, 1'b0, 1'b0, 1'b0, 16'h0000);
        op(`STCB_OP_TMR1MS, 9'd7, 1'b1, 1'b0, 1'b0, 16'h0014);
        chk_rd("timer7 restarted", 1'b0, 9'd7, 16'h0000);
        cmp_bit("timer7 out restarted", 1'b0, timer_out[7]);
        $display("test timers done");
    endtask
    task automatic t_accum;
        op(`STCB_OP_TMR100, 9'd250, 1'b1, 1'b1, 1'b0, 16'h0064);
        idle(1998);
        op(`STCB_OP_TMR100, 9'd250, 1'b1, 1'b1, 1'b0, 16'h0064);
        op(`STCB_OP_TMR100, 9'd250, 1'b0, 1'b1, 1'b0, 16'h0064);
        chk_rd("accum held", 1'b0, 9'd250, 16'h0002);
        op(`STCB_OP_TMR100, 9'd250, 1'b1, 1'b1, 1'b0, 16'h0064);
        idle(998);
        op(`STCB_OP_TMR100, 9'd250, 1'b1, 1'b1, 1'b0, 16'h0064);
        chk_rd("accum resumed", 1'b0, 9'd250, 16'h0003);
        op(`STCB_OP_TMR100, 9'd420, 1'b1, 1'b0, 1'b0, 16'h0064);
        idle(1998);
        op(`STCB_OP_END_SCAN, 9'd0, 1'b0, 1'b0, 1'b0, 16'h0000);
        chk_rd("reserved at scan end", 1'b0, 9'd420, 16'h0002);
        $display("test accumulative done");
    endtask
    task automatic t_counter;
        op(`STCB_OP_CLR_CNT, 9'd0, 1'b0, 1'b0, 1'b0, 16'h0000);
        repeat (3) edge_cnt(9'd0, 16'h0003);
        chk_rd("counter0 three edges", 1'b1, 9'd0, 16'h0003);
        cmp_bit("counter0 before scan end", 1'b0, counter_out[0]);
        op(`STCB_OP_END_SCAN, 9'd0, 1'b0, 1'b0, 1'b0, 16'h0000);
        idle(1);
        cmp_bit("counter0 after scan end", 1'b1, counter_out[0]);
        edge_cnt(9'd0, 16'h0003);
        chk_rd("counter0 stays at setting", 1'b1, 9'd0, 16'h0003);
        op(`STCB_OP_CLR_CNT, 9'd0, 1'b0, 1'b0, 1'b0, 16'h0000);
        chk_rd("counter0 cleared", 1'b1, 9'd0, 16'h0000);
        cmp_bit("counter0 out cleared", 1'b0, counter_out[0]);
        edge_cnt(9'd1, 16'h0000);
        op(`STCB_OP_MOVE, 9'd2, 1'b0, 1'b0, 1'b0, 16'h000a);
        edge_cnt(9'd2, 16'h0005);
        chk_rd("counter2 loads setting", 1'b1, 9'd2, 16'h0005);
        op(`STCB_OP_END_SCAN, 9'd0, 1'b0, 1'b0, 1'b0, 16'h0000);
        idle(1);
        cmp_bit("setting zero first edge", 1'b1, counter_out[1]);
        cmp_bit("counter2 out above setting", 1'b1, counter_out[2]);
        $display("test counters done");
    endtask
    task automatic t_power;
        edge_cnt(9'd300, 16'h0001);
        edge_cnt(9'd4, 16'h0009);
        op(`STCB_OP_END_SCAN, 9'd0, 1'b0, 1'b0, 1'b0, 16'h0000);
        @(posedge sys_clk);
        power_fail <= 1'b1;
        idle(8);
        power_fail <= 1'b0;
        idle(8);
        chk_rd("latched counter kept", 1'b1, 9'd300, 16'h0001);
        cmp_bit("latched out kept", 1'b1, counter_out[300]);
        chk_rd("general counter cleared", 1'b1, 9'd4, 16'h0000);
        chk_rd("accum kept over power", 1'b0, 9'd250, 16'h0003);
        op(`STCB_OP_CLR_CNT, 9'd300, 1'b0, 1'b0, 1'b0, 16'h0000);
        chk_rd("latched cleared", 1'b1, 9'd300, 16'h0000);
        $display("test power loss done");
    endtask
    initial
    begin
        idle(16);
        rst <= 1'b0;
        t_timers();
        t_accum();
        t_counter();
        t_power();
        end_sim();
    end
    // the run needs about 8.2k cycles, under half a millisecond
    initial
    begin
        #2ms;
        bad_count++;
        end_sim();
    end
endmodule // stcb_bank_tb_top
bind stcb_bank stcb_bank_props stcb_bank_props_inst (.sys_clk(sys_clk), .rst(rst), .power_fail(power_fail),
    .op_valid(op_valid), .op_code(op_code), .op_index(op_index), .enable_input(enable_input), .op_accum(op_accum),
    .count_input(count_input), .op_setting(op_setting), .rd_req(rd_req), .rd_sel(rd_sel), .rd_index(rd_index),
    .timer_out(timer_out), .counter_out(counter_out), .rd_valid(rd_valid), .rd_value(rd_value));
`default_nettype wire
